// ===== logic/baud_timer_map.vh
// Register offsets, field positions and reset values
// for the baud-rate timer block. Assumes an AHB-Lite word-addressed slave.
// How it works
// (RULE_01) Either clock-select bit enables baud mode
// (RULE_02) Baud mode counts sixteen bits, upward only
// (RULE_03) Overflow reloads counter from reload value; the code reloads only in baud mode and otherwise wraps to zero
// (RULE_04) Overflow flag untouched while in baud mode
// (RULE_05) Enabled falling pin edge sets edge flag; the code sets it only in baud mode
// (RULE_06) Edge flag with interrupt enable raises request
// (RULE_07) Reload low is LSB, high is MSB
// (RULE_08) Source bit picks external events or clock
// (RULE_09) Overflow tick goes to selected serial direction
`ifndef BAUD_TIMER_MAP_VH
`define BAUD_TIMER_MAP_VH

// Byte offsets
`define OFS_CTRL        8'h00
`define OFS_RELOAD_LO   8'h04
`define OFS_RELOAD_HI   8'h08
`define OFS_COUNT_LO    8'h0C
`define OFS_COUNT_HI    8'h10
`define OFS_STATUS      8'h14
`define OFS_MASK        8'h18

// Control register fields
`define CTRL_RUN        0
`define CTRL_SRC        1
`define CTRL_EXT_EN     3
`define CTRL_TX_SEL     4
`define CTRL_RX_SEL     5
`define CTRL_EDGE_FLAG  6
`define CTRL_OVF_FLAG   7
`define CTRL_WIDTH      8

// Status / mask fields
`define ST_EDGE         0
`define ST_OVF          1
`define ST_WIDTH        2

// Reset values
`define CTRL_RESET      8'h00
`define BYTE_RESET      8'h00
`define MASK_RESET      2'h0

`endif

// ===== logic/baud_timer.v
// Timer used as a baud-rate generator for the serial port, with AHB-Lite
// register access. Assumes one clock; external pins are asynchronous.
`timescale 1ns/10ps
`include "baud_timer_map.vh"

module baud_timer (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        count_pin,
   input  wire        timer_external_control_pin,
   output reg         rx_tick,
   output reg         tx_tick,
   output reg         irq
);

////////////////////////////////////////////////////////////////////////////
// Registers

reg  [7:0]  ctrl_q;
reg  [7:0]  reload_lo_q;
reg  [7:0]  reload_hi_q;
reg  [15:0] count_q;
reg  [1:0]  status_q;
reg  [1:0]  mask_q;
reg         wr_pend_q;
reg  [7:0]  addr_q;
reg  [2:0]  ext_sync_q;
reg  [2:0]  cnt_sync_q;
reg         ext_level_q;
reg         cnt_level_q;

wire        baud_mode;
wire        tick_en;
wire        overflow;
wire        ext_fall;
wire        cnt_rise;
wire        ext_new;
wire        cnt_new;
wire        addr_ph;
wire        rd_status;
wire        wr_fwd;
wire [15:0] reload_val;

// Settled level of a pin: stages two and three must agree before a change
// counts, so a sample caught in mid-transition can never make a false edge
function settled;
   input [2:0] stages;
   input       level;
   begin
      if (stages[1] == stages[2])
         settled = stages[2];
      else
         settled = level;
   end
endfunction

// Byte-wide registers read back zero-extended to a bus word
function [31:0] word_of;
   input [7:0] value;
   begin
      word_of = {24'h00_0000, value};
   end
endfunction

// Either select bit puts the timer in baud mode
assign baud_mode  = ctrl_q[`CTRL_TX_SEL] | ctrl_q[`CTRL_RX_SEL]; // see RULE_01
assign reload_val = {reload_hi_q, reload_lo_q};                   // see RULE_07
assign addr_ph    = hsel & hready & htrans[1];

// Status is cleared on the edge that captures it for the read, so an event
// arriving between capture and clear is never thrown away
assign rd_status  = addr_ph & ~hwrite & (haddr[7:0] == `OFS_STATUS);
// A read directly behind a write to the same register returns the new byte;
// a flag that hardware sets on that same edge only shows on the next read
assign wr_fwd     = wr_pend_q & (addr_q == haddr[7:0]);

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: a change counts once stages two and three agree

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      ext_sync_q  <= 3'h7;
      cnt_sync_q  <= 3'h0;
      ext_level_q <= 1'b1;
      cnt_level_q <= 1'b0;
   end else begin
      ext_sync_q <= {ext_sync_q[1:0], timer_external_control_pin};
      cnt_sync_q <= {cnt_sync_q[1:0], count_pin};
      ext_level_q <= ext_new;
      cnt_level_q <= cnt_new;
   end
end

// Edges are taken between the held level and the newly settled one
assign ext_new  = settled(ext_sync_q, ext_level_q);
assign cnt_new  = settled(cnt_sync_q, cnt_level_q);
assign ext_fall = ext_level_q & ~ext_new;
assign cnt_rise = ~cnt_level_q & cnt_new;

// Source bit chooses external events or every core clock
assign tick_en  = ctrl_q[`CTRL_RUN] &
                  (ctrl_q[`CTRL_SRC] ? cnt_rise : 1'b1); // see RULE_08
assign overflow = tick_en & (count_q == 16'hFFFF);

////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave: zero wait states, always OKAY

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
   end else begin
      wr_pend_q <= addr_ph & hwrite;
      if (addr_ph)
         addr_q <= haddr[7:0];
   end
end

// Read data is registered in the address phase so hrdata comes from a flop
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      hrdata <= 32'h0000_0000;
   end else if (addr_ph & ~hwrite) begin
      case (haddr[7:0])
         `OFS_CTRL:      hrdata <= word_of(wr_fwd ? hwdata[7:0] : ctrl_q);
         `OFS_RELOAD_LO: hrdata <= word_of(wr_fwd ? hwdata[7:0] : reload_lo_q);
         `OFS_RELOAD_HI: hrdata <= word_of(wr_fwd ? hwdata[7:0] : reload_hi_q);
         `OFS_COUNT_LO:  hrdata <= word_of(wr_fwd ? hwdata[7:0] : count_q[7:0]);
         `OFS_COUNT_HI:  hrdata <= word_of(wr_fwd ? hwdata[7:0] : count_q[15:8]);
         `OFS_STATUS:    hrdata <= word_of({6'h00, status_q});
         `OFS_MASK:      hrdata <= word_of({6'h00, (wr_fwd ? hwdata[1:0] : mask_q)});
         default:        hrdata <= 32'h0000_0000;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// Control, reload and mask registers; hardware flag sets win over writes

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      ctrl_q      <= `CTRL_RESET;
      reload_lo_q <= `BYTE_RESET;
      reload_hi_q <= `BYTE_RESET;
      mask_q      <= `MASK_RESET;
   end else begin
      if (wr_pend_q) begin
         case (addr_q)
            `OFS_CTRL:      ctrl_q      <= hwdata[7:0];
            `OFS_RELOAD_LO: reload_lo_q <= hwdata[7:0];
            `OFS_RELOAD_HI: reload_hi_q <= hwdata[7:0];
            `OFS_MASK:      mask_q      <= hwdata[1:0];
            default:        ;
         endcase
      end
      // Edge flag only in baud mode with the pin enabled
      if (baud_mode & ctrl_q[`CTRL_EXT_EN] & ext_fall)
         ctrl_q[`CTRL_EDGE_FLAG] <= 1'b1;                // see RULE_05
      // Overflow flag left alone while the serial port owns overflows
      if (~baud_mode & overflow)
         ctrl_q[`CTRL_OVF_FLAG] <= 1'b1;                 // see RULE_04
   end
end

////////////////////////////////////////////////////////////////////////////
// Counter: sixteen-bit up count, reload on overflow in baud mode

// A software write to a count byte wins over counting in that cycle and the
// other byte holds its value, so load both bytes while the timer is stopped
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      count_q <= 16'h0000;
   end else if (wr_pend_q && addr_q == `OFS_COUNT_LO) begin
      count_q[7:0] <= hwdata[7:0];
   end else if (wr_pend_q && addr_q == `OFS_COUNT_HI) begin
      count_q[15:8] <= hwdata[7:0];
   end else if (overflow & baud_mode) begin
      count_q <= reload_val;                             // see RULE_03
   end else if (tick_en) begin
      count_q <= count_q + 16'h0001;                     // see RULE_02
   end
end

////////////////////////////////////////////////////////////////////////////
// Baud ticks, one cycle per overflow, to each selected direction

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      rx_tick <= 1'b0;
      tx_tick <= 1'b0;
   end else begin
      rx_tick <= overflow & ctrl_q[`CTRL_RX_SEL];        // see RULE_09
      tx_tick <= overflow & ctrl_q[`CTRL_TX_SEL];        // see RULE_09
   end
end

////////////////////////////////////////////////////////////////////////////
// Sticky status, cleared by a read of it; a new event in that cycle wins

always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      status_q <= 2'h0;
      irq      <= 1'b0;
   end else begin
      status_q <= (rd_status ? 2'h0 : status_q) |
                  {~baud_mode & overflow,
                   baud_mode & ctrl_q[`CTRL_EXT_EN] & ext_fall};
      // Mask bits are the interrupt enables for the edge and overflow events
      irq <= |(status_q & mask_q);                       // see RULE_06
   end
end

endmodule

// ===== verif/baud_timer_chk.sv
// Port checker for the baud timer.
// Assumes reload periods above nine cycles and no overflow interrupt unmasked.
`timescale 1ns/10ps
module baud_timer_chk (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire hreadyout,
   input wire hresp,
   input wire timer_external_control_pin,
   input wire rx_tick,
   input wire tx_tick,
   input wire irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Slave never stalls and never errors
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) else $error("hresp not okay");
   // Ticks are single pulses spaced at least nine cycles apart
   a_rx_gap: assert property ($rose(rx_tick) |=> !rx_tick [*8])
      else $error("rx tick too close");
   a_tx_gap: assert property ($rose(tx_tick) |=> !tx_tick [*8])
      else $error("tx tick too close");
   a_ticks_reset: assert property ($rose(hresetn) |-> !rx_tick && !tx_tick)
      else $error("tick out of reset");
   a_irq_reset: assert property ($rose(hresetn) |-> !irq) else $error("irq out of reset");
   // Pin edges pass a synchroniser, so irq cannot follow within two cycles
   a_irq_delay: assert property ($fell(timer_external_control_pin) && !irq |=> !irq ##1 !irq)
      else $error("irq too early");
   a_irq_holds: assert property (irq && !$past(hsel) && !$past(hsel, 2) |=> irq)
      else $error("irq dropped without access");
   a_irq_quiet: assert property (($stable(timer_external_control_pin) && !hsel) [*8] ##0 !irq |=> !irq)
      else $error("irq without cause");
endmodule
bind baud_timer baud_timer_chk baud_timer_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .hreadyout(hreadyout), .hresp(hresp), .timer_external_control_pin(timer_external_control_pin),
   .rx_tick(rx_tick), .tx_tick(tx_tick), .irq(irq));

// ===== verif/serial_tick_sink.sv
// Serial port stand-in that counts the baud ticks it receives.
// Assumes ticks are one-cycle pulses on the block clock.
`timescale 1ns/10ps
module serial_tick_sink (
   input  wire    hclk,
   input  wire    hresetn,
   input  wire    rx_tick,
   input  wire    tx_tick,
   output integer rx_n,
   output integer tx_n
);
   // Count per direction; the bench judges deltas, not absolutes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_n <= 0;
         tx_n <= 0;
      end else begin
         rx_n <= rx_n + rx_tick;
         tx_n <= tx_n + tx_tick;
      end
   end
endmodule

// ===== verif/baud_timer_tb_top.sv
// Self-checking bench for the baud timer over AHB-Lite.
// Assumes the register map header and a zero-wait slave.
`timescale 1ns/10ps
`include "baud_timer_map.vh"
module baud_timer_tb_top;
   logic        hclk, hresetn, hsel, hwrite, count_pin, ext_pin, rx_tick, tx_tick, irq;
   logic        hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   integer      num_errors, n_tests, rx_n, tx_n, r0, t0, k;
   baud_timer baud_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .count_pin(count_pin),
      .timer_external_control_pin(ext_pin), .rx_tick(rx_tick), .tx_tick(tx_tick), .irq(irq));
   serial_tick_sink serial_tick_sink_i (.hclk(hclk), .hresetn(hresetn), .rx_tick(rx_tick),
      .tx_tick(tx_tick), .rx_n(rx_n), .tx_n(tx_n));
   ////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("compares %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic ck(input [31:0] g, input [31:0] e);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Bounded wait for hready; a stuck bus ends the run
   task automatic hold;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 20) begin
         @(posedge hclk);
         k++;
      end
      if (k >= 20) begin
         num_errors++;
         close_out;
      end
   endtask
   // One single transfer; read data lands in q
   task automatic xfer(input [7:0] a, input w, input [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hold;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h00_0000, d};
      hold;
      q = hrdata;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs;
      xfer(`OFS_CTRL, 0, 8'h00); ck(q, 32'h0);
      xfer(`OFS_RELOAD_LO, 1, 8'hF0);
      xfer(`OFS_RELOAD_HI, 1, 8'hFF);
      xfer(`OFS_RELOAD_LO, 0, 8'h00); ck(q, 32'hF0);
      xfer(`OFS_RELOAD_HI, 0, 8'h00); ck(q, 32'hFF);
      xfer(8'h1C, 1, 8'h55);
      xfer(8'h1C, 0, 8'h00); ck(q, 32'h0);
      $display("regs done");
   endtask
   // Count starts at FFF0, so a tick every 16 cycles
   task automatic t_baud(input [7:0] c, input [31:0] er, input [31:0] et);
      xfer(`OFS_COUNT_LO, 1, 8'hF0);
      xfer(`OFS_COUNT_HI, 1, 8'hFF);
      r0 = rx_n;
      t0 = tx_n;
      xfer(`OFS_CTRL, 1, c);
      repeat (56) @(posedge hclk);
      ck(rx_n - r0, er);
      ck(tx_n - t0, et);
      xfer(`OFS_CTRL, 0, 8'h00); ck(q, c);
      xfer(`OFS_CTRL, 1, 8'h00);
      xfer(`OFS_COUNT_HI, 0, 8'h00); ck(q, 32'hFF);
      $display("baud %h done", c);
   endtask
   // Outside baud mode an overflow sets both overflow bits and sends no tick
   task automatic t_plain;
      xfer(`OFS_COUNT_LO, 1, 8'hFA);
      xfer(`OFS_COUNT_HI, 1, 8'hFF);
      r0 = rx_n;
      t0 = tx_n;
      xfer(`OFS_CTRL, 1, 8'h01);
      repeat (12) @(posedge hclk);
      xfer(`OFS_CTRL, 0, 8'h00); ck(q, 32'h81);
      xfer(`OFS_STATUS, 0, 8'h00); ck(q, 32'h2);
      xfer(`OFS_CTRL, 1, 8'h00);
      ck(rx_n + tx_n - r0 - t0, 32'h0);
      $display("plain done");
   endtask
   task automatic t_src;
      xfer(`OFS_COUNT_LO, 1, 8'hF0);
      xfer(`OFS_COUNT_HI, 1, 8'hFF);
      t0 = tx_n;
      xfer(`OFS_CTRL, 1, 8'h13);
      repeat (40) @(posedge hclk);
      ck(tx_n - t0, 32'h0);
      repeat (16) begin
         count_pin <= 1'b1;
         repeat (3) @(posedge hclk);
         count_pin <= 1'b0;
         repeat (3) @(posedge hclk);
      end
      repeat (8) @(posedge hclk);
      ck(tx_n - t0, 32'h1);
      xfer(`OFS_CTRL, 1, 8'h00);
      $display("source done");
   endtask
   task automatic t_edge;
      xfer(`OFS_MASK, 1, 8'h01);
      xfer(`OFS_CTRL, 1, 8'h18);
      ext_pin <= 1'b0;
      for (k = 0; k < 12 && irq !== 1'b1; k++) @(posedge hclk);
      ck(irq, 32'h1);
      if (irq !== 1'b1) close_out;
      xfer(`OFS_STATUS, 0, 8'h00); ck(q, 32'h1);
      xfer(`OFS_CTRL, 0, 8'h00); ck(q, 32'h58);
      repeat (2) @(posedge hclk);
      ck(irq, 32'h0);
      xfer(`OFS_MASK, 1, 8'h00);
      ext_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      ext_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      ck(irq, 32'h0);
      xfer(`OFS_STATUS, 0, 8'h00); ck(q, 32'h1);
      ext_pin <= 1'b1;
      // With the pin input disabled a falling edge must leave no flag
      xfer(`OFS_CTRL, 1, 8'h10);
      repeat (6) @(posedge hclk);
      ext_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      xfer(`OFS_STATUS, 0, 8'h00); ck(q, 32'h0);
      xfer(`OFS_CTRL, 0, 8'h00); ck(q, 32'h10);
      ext_pin <= 1'b1;
      xfer(`OFS_CTRL, 1, 8'h00);
      $display("edge done");
   endtask
   ////////////////////////////////////////////////////////////
   // Free-running 100 MHz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Reset for three cycles, then the scenarios in turn
   initial begin
      {hresetn, hsel, hwrite, count_pin, htrans, haddr, hwdata} = '0;
      ext_pin = 1'b1;
      num_errors = 0;
      n_tests = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_baud(8'h21, 32'h3, 32'h0);
      t_baud(8'h11, 32'h0, 32'h3);
      t_baud(8'h31, 32'h3, 32'h3);
      t_plain;
      t_src;
      t_edge;
      close_out;
   end
endmodule
